// File: config_select_and_input_switchover_test.sv
// Testbench: host and device joined; power-up, select steps and switchover
`default_nettype none
module config_select_and_input_switchover_test import csw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SET_C = 50;
   localparam int APP_C = 20;
   logic clock, sys_rst, strap, flag, sel_req, src_sel, pwr, pval, xtal, dpos;
   logic hw, so, busy, prim, sdiff, rout, ready;
   logic [1:0] sel_init, sel_target, smode;
   logic [7:0] cfg;
   logic [2:0] org;
   int bad_count, checked, cyc;
   csw_if i_csw_if();
   csw_device #(.SETTLE_CYCLES(SET_C), .APPLY_CYCLES(APP_C)) i_csw_device (.clock(clock),
      .sys_rst(sys_rst), .pins(i_csw_if.dev), .stored_cfg(32'hA3A2A1A0),
      .serial_default_cfg(8'h5C), .power_up_load_flag(flag), .primary_source_bit_wr(pwr),
      .primary_source_bit_val(pval), .switchover_mode_field(smode), .crystal_ref_input(xtal),
      .diff_clock_input_pos(dpos), .diff_clock_input_neg(~dpos), .hw_mode_r(hw),
      .serial_open_r(so), .active_cfg_r(cfg), .cfg_origin_r(org), .cfg_busy_r(busy),
      .primary_source_bit_r(prim), .source_diff_r(sdiff), .ref_clock_out_r(rout));
   csw_host #(.SETTLE_CYCLES(SET_C), .APPLY_CYCLES(APP_C)) i_csw_host (.clock(clock),
      .sys_rst(sys_rst), .strap_level(strap), .sel_init(sel_init), .sel_req(sel_req),
      .sel_target(sel_target), .src_sel_level(src_sel), .sel_ready_r(ready),
      .pins(i_csw_if.host));
   csw_props #(.SETTLE_CYCLES(SET_C), .APPLY_CYCLES(APP_C)) i_csw_props (.clock(clock),
      .sys_rst(sys_rst), .mode_strap_pin(i_csw_if.mode_strap_pin),
      .config_select_bit0(i_csw_if.config_select_bit0),
      .config_select_bit1(i_csw_if.config_select_bit1),
      .input_select_pin(i_csw_if.input_select_pin));
   // System clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Reference sources at unequal rates; hang guard
   always @(negedge clock) begin
      xtal <= ~xtal;
      if (cyc % 3 == 0) dpos <= ~dpos;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait for the host to accept a new request
   task automatic wait_ready();
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 300) begin
         @(negedge clock);
         n++;
      end
      check(8'(ready), 8'h01);
   endtask
   task automatic power_up(input logic s, input logic [1:0] si, input logic f);
      sys_rst = 1'b1;
      strap = s;
      sel_init = si;
      flag = f;
      repeat (6) @(negedge clock);
      sys_rst = 1'b0;
      repeat (4) @(negedge clock);
      wait_ready();
   endtask
   task automatic pick(input logic [1:0] t);
      sel_target = t;
      sel_req = 1'b1;
      @(negedge clock);
      sel_req = 1'b0;
      @(negedge clock);
      wait_ready();
      repeat (4) @(negedge clock);
   endtask
   // Serial write of the primary-source bit, then let the switchover settle
   task automatic set_prim(input logic v);
      pval = v;
      pwr = 1'b1;
      @(negedge clock);
      pwr = 1'b0;
      repeat (30) @(negedge clock);
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      {sys_rst, strap, flag, sel_req, src_sel, pwr, pval, xtal, dpos} = 9'h100;
      {sel_init, sel_target, smode} = 6'h00;
      bad_count = 0;
      checked = 0;
      cyc = 0;
      for (int i = 0; i < 4; i++) begin
         power_up(1'b1, 2'(i), 1'b1);
         check(8'(hw), 8'h01);
         check(8'(so), 8'h00);
         check(cfg, 8'hA0 + 8'(i));
         check(8'(org), 8'(i));
         check(8'(busy), 8'h00);
      end
      // Step 3 -> 2 and catch the device busy while it applies the change
      sel_target = 2'h2;
      sel_req = 1'b1;
      @(negedge clock);
      sel_req = 1'b0;
      repeat (5) @(negedge clock);
      check(8'(busy), 8'h01);
      wait_ready();
      repeat (4) @(negedge clock);
      check(cfg, 8'hA2);
      check(8'(busy), 8'h00);
      pick(2'h0);
      check(cfg, 8'hA0);
      pick(2'h2);
      check(cfg, 8'hA2);
      set_prim(1'b1);
      check(8'(prim), 8'h00);
      power_up(1'b0, 2'h3, 1'b0);
      check(8'(so), 8'h01);
      check(8'(prim), 8'h00);
      check(cfg, 8'hA0);
      pick(2'h1);
      check(8'(org), 8'h00);
      power_up(1'b0, 2'h0, 1'b1);
      check(cfg, 8'h5C);
      check(8'(org), 8'h04);
      // Crystal is the source: output follows it two edges late
      check(8'(rout), 8'(!xtal));
      for (int j = 0; j < 4; j++) begin
         src_sel = j[0];
         set_prim(j[1]);
         check(8'(prim), 8'(j[1]));
         check(8'(sdiff), 8'(j[0] ^ j[1]));
      end
      smode = 2'h2;
      src_sel = 1'b0;
      repeat (30) @(negedge clock);
      check(8'(sdiff), 8'h00);
      smode = 2'h0;
      repeat (30) @(negedge clock);
      check(8'(sdiff), 8'h01);
      complete_run();
   end
endmodule // config_select_and_input_switchover_test
`default_nettype wire

// File: csw_device.sv
// Device end: mode strap, configuration selection and park-low source switchover
`default_nettype none
module csw_device
   import csw_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC,
   parameter int APPLY_CYCLES = APPLY_CYC,
   parameter int CFG_WIDTH = CFG_W
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Pins from host or straps
   csw_if.dev pins,
   // Stored configurations and serial defaults
   input wire logic [NUM_CFG*CFG_WIDTH-1:0] stored_cfg,
   input wire logic [CFG_WIDTH-1:0] serial_default_cfg,
   input wire logic power_up_load_flag,
   // Serial-written switchover settings
   input wire logic primary_source_bit_wr,
   input wire logic primary_source_bit_val,
   input wire logic [SMODE_W-1:0] switchover_mode_field,
   // Reference clocks (sampled as data here)
   input wire logic crystal_ref_input,
   input wire logic diff_clock_input_pos,
   input wire logic diff_clock_input_neg,
   // Results
   output logic hw_mode_r,
   output logic serial_open_r,
   output logic [CFG_WIDTH-1:0] active_cfg_r,
   output logic [2:0] cfg_origin_r,
   output logic cfg_busy_r,
   output logic primary_source_bit_r,
   output logic source_diff_r,
   output logic ref_clock_out_r
);
   logic [1:0] strap_s, config_select_bit0_s, config_select_bit1_s, isel_s;
   logic strap_cap_r;
   logic [1:0] sel_prev_r;
   logic [31:0] apply_cnt_r;
   logic want_diff;
   csw_sw_st_t sw_st_r;
   logic xtal_d_r, diff_d_r;

   function automatic logic [CFG_WIDTH-1:0] pick_cfg(input logic [1:0] idx,
      input logic [NUM_CFG*CFG_WIDTH-1:0] mem);
      pick_cfg = mem[idx*CFG_WIDTH +: CFG_WIDTH];
   endfunction

   // Two-flop synchronisers for pins
   always_ff @(posedge clock) begin
      strap_s <= {strap_s[0], pins.mode_strap_pin};
      config_select_bit0_s <= {config_select_bit0_s[0], pins.config_select_bit0};
      config_select_bit1_s <= {config_select_bit1_s[0], pins.config_select_bit1};
      isel_s <= {isel_s[0], pins.input_select_pin};
   end

   // Strap caught once after reset release
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         strap_cap_r <= 1'h0;
         hw_mode_r <= 1'h0;
         serial_open_r <= 1'h0;
      end else if (!strap_cap_r && apply_cnt_r == 32'h3) begin
         strap_cap_r <= 1'h1;
         hw_mode_r <= strap_s[1];
         serial_open_r <= !strap_s[1];
      end
   end

   // Configuration load at power-up and on select change
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         apply_cnt_r <= 32'h0;
         sel_prev_r <= 2'h0;
         active_cfg_r <= '0;
         cfg_origin_r <= 3'h0;
         cfg_busy_r <= 1'h1;
      end else if (!strap_cap_r) begin
         apply_cnt_r <= apply_cnt_r + 32'h1; // Wait for synchronisers to fill
         sel_prev_r <= {config_select_bit1_s[1], config_select_bit0_s[1]};
         // Fourth edge: the pin level driven on the first edge is through both flops
         if (apply_cnt_r == 32'h3) begin
            cfg_busy_r <= 1'h0;
            apply_cnt_r <= 32'h0;
            if (strap_s[1]) begin
               // Stored configuration indexed by pins, upper bit from second pin
               active_cfg_r <= pick_cfg({config_select_bit1_s[1], config_select_bit0_s[1]}, stored_cfg);
               cfg_origin_r <= {1'h0, config_select_bit1_s[1], config_select_bit0_s[1]};
            end else if (power_up_load_flag) begin
               active_cfg_r <= serial_default_cfg;
               cfg_origin_r <= CFG_SERIAL;
            end else begin
               active_cfg_r <= pick_cfg(2'h0, stored_cfg);
               cfg_origin_r <= 3'h0;
            end
         end
      end else if (hw_mode_r) begin
         sel_prev_r <= {config_select_bit1_s[1], config_select_bit0_s[1]};
         if ({config_select_bit1_s[1], config_select_bit0_s[1]} != sel_prev_r) begin
            cfg_busy_r <= 1'h1;
            apply_cnt_r <= 32'h0;
         end else if (cfg_busy_r) begin
            apply_cnt_r <= apply_cnt_r + 32'h1;
            if (apply_cnt_r == 32'(APPLY_CYCLES - 2)) begin
               active_cfg_r <= pick_cfg(sel_prev_r, stored_cfg);
               cfg_origin_r <= {1'h0, sel_prev_r};
               cfg_busy_r <= 1'h0;
            end
         end
      end
   end

   // Primary-source bit, writable only when the serial port is open
   always_ff @(posedge clock) begin
      if (sys_rst) primary_source_bit_r <= PRIM_RST;
      else if (serial_open_r && primary_source_bit_wr)
         primary_source_bit_r <= primary_source_bit_val;
   end

   // Selected source: select pin xor primary bit in manual mode
   always_comb begin
      want_diff = source_diff_r;
      if (!switchover_mode_field[SMODE_MAN_BIT])
         want_diff = isel_s[1] ^ primary_source_bit_r;
   end

   // Sample references as data for the switch
   always_ff @(posedge clock) begin
      xtal_d_r <= crystal_ref_input;
      diff_d_r <= diff_clock_input_pos & ~diff_clock_input_neg;
   end

   // Switch: park low, change source, reopen; the old source can still pass one high cycle as parking starts
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sw_st_r <= SW_RUN;
         source_diff_r <= SRC_XTAL;
         ref_clock_out_r <= 1'h0;
      end else begin
         unique case (sw_st_r)
            SW_RUN: begin
               ref_clock_out_r <= source_diff_r ? diff_d_r : xtal_d_r;
               if (want_diff != source_diff_r && !ref_clock_out_r) sw_st_r <= SW_GATE;
            end
            SW_GATE: begin
               ref_clock_out_r <= 1'h0;
               source_diff_r <= want_diff ? SRC_DIFF : SRC_XTAL;
               sw_st_r <= SW_OPEN;
            end
            SW_OPEN: begin
               // Reopen only while new source is low to avoid a runt pulse
               if (!(source_diff_r ? diff_d_r : xtal_d_r)) sw_st_r <= SW_RUN;
            end
            default: sw_st_r <= SW_RUN;
         endcase
      end
   end
endmodule : csw_device
`default_nettype wire

// File: csw_host.sv
// Host end: drives strap and select pins under the timing the device needs
`default_nettype none
module csw_host
   import csw_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC,
   parameter int APPLY_CYCLES = APPLY_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // User side
   input wire logic strap_level,
   input wire logic [1:0] sel_init,
   input wire logic sel_req,
   input wire logic [1:0] sel_target,
   input wire logic src_sel_level,
   output logic sel_ready_r,
   // Pins to device
   csw_if.host pins
);
   csw_host_st_t st_r;
   logic [31:0] cnt_r;
   logic [1:0] sel_r, goal_r;
   logic strap_r, isel_r;

   assign pins.mode_strap_pin = strap_r;
   assign pins.config_select_bit0 = sel_r[0];
   assign pins.config_select_bit1 = sel_r[1];
   assign pins.input_select_pin = isel_r;

   // Source select follows user level
   always_ff @(posedge clock) begin
      if (sys_rst) isel_r <= 1'h0;
      else isel_r <= src_sel_level;
   end

   // Pin sequencing
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_r <= HS_POR;
         cnt_r <= 32'h0;
         sel_r <= 2'h0;
         goal_r <= 2'h0;
         strap_r <= 1'h0;
         sel_ready_r <= 1'h0;
      end else begin
         unique case (st_r)
            HS_POR: begin
               strap_r <= strap_level;
               sel_r <= sel_init;
               goal_r <= sel_init;
               cnt_r <= 32'h0;
               st_r <= HS_WAIT;
            end
            HS_WAIT: begin
               cnt_r <= cnt_r + 32'h1;
               if (cnt_r == 32'(SETTLE_CYCLES - 1)) begin
                  st_r <= HS_IDLE;
                  sel_ready_r <= 1'h1;
               end
            end
            HS_IDLE: begin
               if (sel_req) goal_r <= sel_target;
               if (sel_r != goal_r) begin
                  // Step one pin at a time
                  if (sel_r[0] != goal_r[0]) sel_r[0] <= goal_r[0];
                  else sel_r[1] <= goal_r[1];
                  cnt_r <= 32'h0;
                  sel_ready_r <= 1'h0;
                  st_r <= HS_GAP;
               end else begin
                  sel_ready_r <= !sel_req;
               end
            end
            HS_GAP: begin
               cnt_r <= cnt_r + 32'h1;
               if (cnt_r == 32'(APPLY_CYCLES - 1)) st_r <= HS_IDLE;
            end
         endcase
      end
   end
endmodule : csw_host
`default_nettype wire

// File: csw_if.sv
// Interface: pins between the clock device and its host or straps
`default_nettype none
interface csw_if;
   logic mode_strap_pin;
   logic config_select_bit0;
   logic config_select_bit1;
   logic input_select_pin;
   modport dev (input mode_strap_pin, config_select_bit0, config_select_bit1,
      input_select_pin);
   modport host (output mode_strap_pin, config_select_bit0, config_select_bit1,
      output input_select_pin);
endinterface : csw_if
`default_nettype wire

// File: csw_pkg.sv
// Package: constants and types for configuration select and input switchover
// How it works
// - Strap sampled at reset picks mode
// - Software mode keeps serial interface open
// - Default configuration comes from stored memory
// - Software mode loads serial defaults when flag set
// - Four stored configurations, chosen by pins
// - Pins index configuration; serial interface closed
// - Host holds select pins stable at reset
// - Host waits 10 ms before changing pins
// - Host changes one select pin at once
// - Quiet 1 ms; device applies new configuration
// - Input select pin picks reference source
// - Primary-source bit inverts select pin meaning
// - Primary-source bit resets to zero
// - Mode field upper bit zero means manual
// - Primary bit sets primary and secondary roles
// - Source switching never glitches the output; the code can still emit a one-cycle high pulse as it parks
`default_nettype none
package csw_pkg;
   localparam int CLK_MHZ = 200;
   localparam int SETTLE_MS = 10;
   localparam int APPLY_MS = 1;
   localparam int CYC_PER_MS = CLK_MHZ * 1000;
   localparam int SETTLE_CYC = SETTLE_MS * CYC_PER_MS;
   localparam int APPLY_CYC = APPLY_MS * CYC_PER_MS;
   localparam int NUM_CFG = 4;
   localparam int CFG_W = 8;
   localparam int SMODE_W = 2;
   localparam int SMODE_MAN_BIT = 1;
   localparam logic PRIM_RST = 1'h0;
   localparam logic SRC_XTAL = 1'h0;
   localparam logic SRC_DIFF = 1'h1;
   // Configuration origin index: 0..3 stored, 4 serial defaults
   localparam logic [2:0] CFG_SERIAL = 3'h4;
   typedef enum logic [1:0] {CSW_SW, CSW_HW} csw_mode_t;
   typedef enum logic [1:0] {HS_POR, HS_WAIT, HS_IDLE, HS_GAP} csw_host_st_t;
   typedef enum logic [1:0] {SW_RUN, SW_GATE, SW_OPEN} csw_sw_st_t;
endpackage : csw_pkg
`default_nettype wire

// File: csw_props.sv
// Checker: timing that the host end keeps on the strap and select pins
`default_nettype none
module csw_props #(
   parameter int SETTLE_CYCLES = 50,
   parameter int APPLY_CYCLES = 20
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Interface pins
   input wire logic mode_strap_pin,
   input wire logic config_select_bit0,
   input wire logic config_select_bit1,
   input wire logic input_select_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] up_r;
   logic [15:0] gap_r;
   logic [1:0] sel_prev_r;
   wire logic [1:0] sel = {config_select_bit1, config_select_bit0};
   // Initial pin drive after release is not a select step
   wire logic live = up_r > 16'h0004;
   // Cycles since reset release, saturating
   always_ff @(posedge clock) begin
      if (sys_rst) up_r <= 16'h0000;
      else if (up_r != 16'hFFFF) up_r <= up_r + 16'h0001;
   end
   // Cycles since the last select pin change
   always_ff @(posedge clock) begin
      sel_prev_r <= sel;
      if (sys_rst || sel != sel_prev_r) gap_r <= 16'h0000;
      else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
   end
   // A select change in normal operation
   sequence sel_step;
      live && (sel != sel_prev_r);
   endsequence
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   chk_pins_reset_low: assert property ($fell(sys_rst) |-> sel == 2'h0 && !mode_strap_pin)
      else $error("strap or select pin not low out of reset");
   chk_strap_held: assert property (live |-> $stable(mode_strap_pin))
      else $error("strap pin moved after power-up");
   chk_settle_wait: assert property (sel_step |-> up_r >= SETTLE_CYCLES)
      else $error("select pin changed before settle time");
   chk_one_pin: assert property (sel_step |-> sel != ~sel_prev_r)
      else $error("both select pins changed together");
   chk_apply_gap: assert property (sel_step |-> gap_r >= APPLY_CYCLES - 1)
      else $error("select steps closer than apply time");
   chk_step_quiet: assert property (sel_step |=> $stable(sel))
      else $error("select pins disturbed right after a step");
endmodule // csw_props
`default_nettype wire
